// ---- logic/tos_ext_sync.sv ----
`timescale 1ns/1ps
module tos_ext_sync
  import tos_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } tos_sync_type;

  tos_sync_type s_q;
  tos_sync_type s_d;

  // first stage feeds only the second one
  always_comb begin
    s_d      = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.sync;
  assign rise  = s_q.sync & ~s_q.prev;
  assign fall  = ~s_q.sync & s_q.prev;

endmodule : tos_ext_sync

// ---- logic/tos_pkg.sv ----
package tos_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // byte addresses of the word registers
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
  localparam logic [ADDR_W-1:0] PERIOD_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] PULSE_OFS  = 4'h8;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'hc;

  // control word fields
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_MODE_LSB = 8;
  localparam int unsigned MODE_W        = 5;

  // status word fields
  localparam int unsigned STAT_CNT_LSB  = 0;
  localparam int unsigned STAT_PWM_BIT  = 16;
  localparam int unsigned STAT_RUN_BIT  = 17;
  localparam int unsigned STAT_BUSY_BIT = 18;

  // byte lanes that carry the fields
  localparam int unsigned LANE_LO   = 0;
  localparam int unsigned LANE_MODE = 1;

  localparam logic [MODE_W-1:0] MODE_EOS_RISE  = 5'h09;
  localparam logic [MODE_W-1:0] MODE_EOS_FALL  = 5'h0a;
  localparam logic [MODE_W-1:0] MODE_EOS_BOTH  = 5'h0b;
  localparam logic [MODE_W-1:0] MODE_HLE_RISE  = 5'h0c;
  localparam logic [MODE_W-1:0] MODE_HLE_FALL  = 5'h0d;
  localparam logic [MODE_W-1:0] MODE_LRE_LOW   = 5'h0e;
  localparam logic [MODE_W-1:0] MODE_LRE_HIGH  = 5'h0f;
  localparam logic [MODE_W-1:0] MODE_MONO_RISE = 5'h11;
  localparam logic [MODE_W-1:0] MODE_MONO_FALL = 5'h12;
  localparam logic [MODE_W-1:0] MODE_MONO_BOTH = 5'h13;
  localparam logic [MODE_W-1:0] MODE_LHL_LOW   = 5'h16;
  localparam logic [MODE_W-1:0] MODE_LHL_HIGH  = 5'h17;

  localparam logic [MODE_W-1:0] MODE_RST_VAL = 5'h00;

  // timer clocks from a hardware-limit reset edge to counting again
  localparam int unsigned HOLD_CLKS = 2;

  typedef enum logic [2:0] {
    TOS_KIND_NONE = 3'h0,
    TOS_KIND_EOS  = 3'h1,
    TOS_KIND_HLE  = 3'h2,
    TOS_KIND_LRE  = 3'h3,
    TOS_KIND_MONO = 3'h4,
    TOS_KIND_LHL  = 3'h5
  } tos_kind_type;

  typedef enum logic [3:0] {
    TOS_ST_WAIT = 4'h1,
    TOS_ST_RUN  = 4'h2,
    TOS_ST_HOLD = 4'h4,
    TOS_ST_DONE = 4'h8
  } tos_state_type;

endpackage : tos_pkg

// ---- logic/tos_timer.sv ----
`timescale 1ns/1ps
// Overview of operation
// - in edge one-shot modes the timer waits, after run is set, for the chosen edge (rising 01001, falling 01010, either 01011).
// - in edge one-shot modes a period match clears run and stops the timer.
// - in edge one-shot modes, after software clears run, counting resumes only when run is set again and a new edge arrives.
// - in edge one-shot modes the start edge raises pwm drive, the pulse-width match drops it, and it stays low at the period halt.
// - in hardware-limit edge modes the first edge after run is set starts counting and each later edge resets the count (rising 01100, falling 01101).
// - in hardware-limit edge modes the count runs again by itself two clocks after each reset edge.
// - in hardware-limit edge modes a period match resets the count and clears run, and edges are ignored while run is clear.
// - in hardware-limit edge modes the start edge and each reset edge raise pwm drive, which drops at the pulse-width match.
// - in level-reset edge-start modes the count is held at zero at the reset level and starts on the move to the active level while run is set (low 01110, high 01111).
// - in level-reset edge-start modes a period match resets the count and clears run, and any clearing of run demands a fresh edge after run is set.
// - in level-reset edge-start modes drive rises on the start edge, drops at the pulse-width match and does not rise at the period clear.
// - in monostable modes the timer starts on the chosen edge after run is set and stops incrementing at the period match (10001, 10010, 10011).
// - in monostable modes only the start edge raises drive, the period match does not, and extra edges while counting leave drive alone.
// - in level hardware-limit modes the timer is held reset at the reset level and starts when run is set and the level is inactive, whichever comes last (low 10110, high 10111).
// - in level hardware-limit modes a period match resets the count and clears run, and the timer stays reset until both start conditions hold again.
// - in level hardware-limit modes drive rises on whichever event starts the timer, the level change or the setting of run.
module tos_timer
  import tos_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              external_trigger_signal,
  output logic      [CNT_W-1:0]  timer_count,
  output logic                   pwm_drive,
  output logic                   timer_match_output
);

  if (CNT_W < 2 || CNT_W > 16) begin : g_chk
    $error("tos_timer: CNT_W must be 2 to 16");
  end

  localparam logic [1:0] HOLD_LAST = 2'(HOLD_CLKS - 1);

  typedef struct packed {
    logic                run;
    logic [MODE_W-1:0]   mode;
    logic [CNT_W-1:0]    period_value;
    logic [CNT_W-1:0]    pulse_width_value;
    logic [CNT_W-1:0]    count;
    logic                pwm;
    logic                match;
    logic [1:0]          hold;
    tos_state_type       st;
    logic                ack;
    logic [DATA_W-1:0]   rdata;
  } tos_regs_type;

  tos_regs_type r_q;
  tos_regs_type r_d;

  logic ext_level;
  logic ext_rise;
  logic ext_fall;

  tos_ext_sync u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (external_trigger_signal),
    .level    (ext_level),
    .rise     (ext_rise),
    .fall     (ext_fall)
  );

  function automatic tos_kind_type mode_kind(input logic [MODE_W-1:0] m);
    case (m)
      MODE_EOS_RISE, MODE_EOS_FALL, MODE_EOS_BOTH:    mode_kind = TOS_KIND_EOS;
      MODE_HLE_RISE, MODE_HLE_FALL:                   mode_kind = TOS_KIND_HLE;
      MODE_LRE_LOW, MODE_LRE_HIGH:                    mode_kind = TOS_KIND_LRE;
      MODE_MONO_RISE, MODE_MONO_FALL, MODE_MONO_BOTH: mode_kind = TOS_KIND_MONO;
      MODE_LHL_LOW, MODE_LHL_HIGH:                    mode_kind = TOS_KIND_LHL;
      default:                                        mode_kind = TOS_KIND_NONE;
    endcase
  endfunction : mode_kind

  // edge that starts or resets the timer in the current mode
  function automatic logic mode_edge(input logic [MODE_W-1:0] m,
                                     input logic rs,
                                     input logic fl);
    case (m)
      MODE_EOS_RISE, MODE_HLE_RISE, MODE_MONO_RISE: mode_edge = rs;
      MODE_EOS_FALL, MODE_HLE_FALL, MODE_MONO_FALL: mode_edge = fl;
      MODE_EOS_BOTH, MODE_MONO_BOTH:                mode_edge = rs | fl;
      MODE_LRE_LOW, MODE_LHL_LOW:                   mode_edge = rs;
      MODE_LRE_HIGH, MODE_LHL_HIGH:                 mode_edge = fl;
      default:                                      mode_edge = 1'b0;
    endcase
  endfunction : mode_edge

  // level modes: is the trigger at its reset level
  function automatic logic at_reset(input logic [MODE_W-1:0] m,
                                    input logic lv);
    case (m)
      MODE_LRE_LOW, MODE_LHL_LOW:   at_reset = ~lv;
      MODE_LRE_HIGH, MODE_LHL_HIGH: at_reset = lv;
      default:                      at_reset = 1'b0;
    endcase
  endfunction : at_reset

  tos_kind_type kind;
  logic         edge_hit;
  logic         rst_lvl;
  logic         wr_go;
  logic         rd_go;
  logic         ctrl_wr;
  logic         new_run;
  logic [MODE_W-1:0] new_mode;
  logic         per_hit;
  logic         pw_hit;

  always_comb begin
    kind     = mode_kind(r_q.mode);
    edge_hit = mode_edge(r_q.mode, ext_rise, ext_fall);
    rst_lvl  = at_reset(r_q.mode, ext_level);
    wr_go    = avs_write & r_q.ack;
    rd_go    = avs_read & ~avs_write & ~r_q.ack;
    ctrl_wr  = wr_go & (avs_address == CTRL_OFS);
    new_run  = r_q.run;
    new_mode = r_q.mode;
    if (ctrl_wr && avs_byteenable[LANE_LO]) begin
      new_run = avs_writedata[CTRL_RUN_BIT];
    end
    if (ctrl_wr && avs_byteenable[LANE_MODE]) begin
      new_mode = avs_writedata[CTRL_MODE_LSB +: MODE_W];
    end
    per_hit = (r_q.count == r_q.period_value);
    pw_hit  = (r_q.count == r_q.pulse_width_value);
  end

  always_comb begin
    r_d       = r_q;
    r_d.match = 1'b0;
    r_d.ack   = (avs_read | avs_write) & ~r_q.ack;

    // timer engine, acting on the values held before this bus cycle
    if (kind == TOS_KIND_NONE) begin
      r_d.count = '0;
      r_d.pwm   = 1'b0;
      r_d.st    = TOS_ST_WAIT;
    end else if (!r_q.run) begin
      // edges ignored while stopped; one-shot and monostable keep count
      r_d.st = TOS_ST_WAIT;
      if (kind != TOS_KIND_EOS && kind != TOS_KIND_MONO) begin
        r_d.count = '0;
      end
    end else begin
      case (r_q.st)
        TOS_ST_WAIT: begin
          if (kind == TOS_KIND_LHL) begin
            r_d.count = '0;
            if (!rst_lvl) begin
              r_d.st  = TOS_ST_RUN;
              r_d.pwm = 1'b1;
            end
          end else if (kind == TOS_KIND_LRE && rst_lvl) begin
            r_d.count = '0;
          end else if (edge_hit) begin
            r_d.st  = TOS_ST_RUN;
            r_d.pwm = 1'b1;
            if (kind != TOS_KIND_EOS) begin
              r_d.count = '0;
            end
          end
        end
        TOS_ST_RUN: begin
          if (pw_hit) begin
            r_d.pwm = 1'b0;
          end
          if ((kind == TOS_KIND_LRE || kind == TOS_KIND_LHL) && rst_lvl) begin
            // held at zero; drive kept until the count reaches the width
            r_d.count = '0;
            r_d.st    = TOS_ST_WAIT;
          end else if (kind == TOS_KIND_HLE && edge_hit) begin
            r_d.count = '0;
            r_d.hold  = '0;
            r_d.pwm   = 1'b1;
            r_d.st    = TOS_ST_HOLD;
          end else if (per_hit) begin
            r_d.match = 1'b1;
            if (kind == TOS_KIND_MONO) begin
              r_d.st = TOS_ST_DONE;
            end else begin
              r_d.count = '0;
              r_d.run   = 1'b0;
              r_d.pwm   = 1'b0;
              r_d.st    = TOS_ST_WAIT;
            end
          end else begin
            r_d.count = r_q.count + 1'b1;
          end
        end
        TOS_ST_HOLD: begin
          r_d.count = '0;
          if (edge_hit) begin
            r_d.hold = '0;
            r_d.pwm  = 1'b1;
          end else if (r_q.hold == HOLD_LAST) begin
            // first step lands on the second clock after the reset edge
            r_d.st    = TOS_ST_RUN;
            r_d.count = r_q.count + 1'b1;
          end else begin
            r_d.hold = r_q.hold + 1'b1;
          end
        end
        TOS_ST_DONE: begin
          if (edge_hit) begin
            // fresh edge after the halt starts another pulse
            r_d.count = '0;
            r_d.pwm   = 1'b1;
            r_d.st    = TOS_ST_RUN;
          end
        end
        default: begin
          r_d.st = TOS_ST_WAIT;
        end
      endcase
    end

    // software write lands last so a write in the match cycle is kept
    if (ctrl_wr) begin
      r_d.run = new_run;
      if (new_mode != r_q.mode) begin
        r_d.mode  = new_mode;
        r_d.count = '0;
        r_d.pwm   = 1'b0;
        r_d.st    = TOS_ST_WAIT;
      end
    end
    if (wr_go && avs_address == PERIOD_OFS && avs_byteenable[LANE_LO]) begin
      r_d.period_value = avs_writedata[CNT_W-1:0];
    end
    if (wr_go && avs_address == PULSE_OFS && avs_byteenable[LANE_LO]) begin
      r_d.pulse_width_value = avs_writedata[CNT_W-1:0];
    end

    if (rd_go) begin
      r_d.rdata = '0;
      case (avs_address)
        CTRL_OFS: begin
          r_d.rdata[CTRL_RUN_BIT]                 = r_q.run;
          r_d.rdata[CTRL_MODE_LSB +: MODE_W]      = r_q.mode;
        end
        PERIOD_OFS: r_d.rdata[CNT_W-1:0] = r_q.period_value;
        PULSE_OFS:  r_d.rdata[CNT_W-1:0] = r_q.pulse_width_value;
        STATUS_OFS: begin
          r_d.rdata[STAT_CNT_LSB +: CNT_W] = r_q.count;
          r_d.rdata[STAT_PWM_BIT]          = r_q.pwm;
          r_d.rdata[STAT_RUN_BIT]          = r_q.run;
          r_d.rdata[STAT_BUSY_BIT]         = (r_q.st != TOS_ST_WAIT);
        end
        default: r_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q                   <= '0;
      r_q.mode              <= MODE_RST_VAL;
      r_q.period_value      <= '1;
      r_q.pulse_width_value <= '0;
      r_q.st                <= TOS_ST_WAIT;
    end else begin
      r_q <= r_d;
    end
  end

  // one wait cycle per access, answered from the registered word
  assign avs_waitrequest    = (avs_read | avs_write) & ~r_q.ack;
  assign avs_readdata       = r_q.rdata;
  assign timer_count        = r_q.count;
  assign pwm_drive          = r_q.pwm;
  assign timer_match_output = r_q.match;

endmodule : tos_timer

// ---- test/tb_tos_timer.sv ----
`timescale 1ns/1ps
module tb_tos_timer
  import tos_pkg::*;
;
  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic              l0;
    logic              l1;
    logic [7:0]        cnt;
    logic              run;
  } tos_row_type;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hf;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              trig_req = 1'b0;
  logic              trig;
  logic [7:0]        timer_count;
  logic              pwm_drive;
  logic              timer_match_output;
  logic              pwm_q = 1'b0;
  int                failures = 0;
  int                n_tests = 0;
  int                cyc = 0;
  int                rises = 0;
  logic [DATA_W-1:0] d;
  int                base;
  int                n;
  tos_row_type rows [13] = '{
    '{MODE_EOS_RISE, 1'b0, 1'b1, 8'h00, 1'b0},
    '{MODE_EOS_FALL, 1'b1, 1'b0, 8'h00, 1'b0},
    '{MODE_EOS_BOTH, 1'b1, 1'b0, 8'h00, 1'b0},
    '{MODE_HLE_RISE, 1'b0, 1'b1, 8'h00, 1'b0},
    '{MODE_HLE_FALL, 1'b1, 1'b0, 8'h00, 1'b0},
    '{MODE_LRE_LOW, 1'b0, 1'b1, 8'h00, 1'b0},
    '{MODE_LRE_HIGH, 1'b1, 1'b0, 8'h00, 1'b0},
    '{MODE_MONO_RISE, 1'b0, 1'b1, 8'h05, 1'b1},
    '{MODE_MONO_FALL, 1'b1, 1'b0, 8'h05, 1'b1},
    '{MODE_MONO_BOTH, 1'b0, 1'b1, 8'h05, 1'b1},
    '{MODE_LHL_LOW, 1'b0, 1'b1, 8'h00, 1'b0},
    '{MODE_LHL_HIGH, 1'b1, 1'b0, 8'h00, 1'b0},
    '{MODE_LHL_LOW, 1'b1, 1'b1, 8'h00, 1'b0}};
  tos_timer #(.CNT_W(8)) i_tos_timer (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_trigger_signal(trig), .timer_count(timer_count),
    .pwm_drive(pwm_drive), .timer_match_output(timer_match_output));
  tos_trig_src i_tos_trig_src (.clk(clk), .level_req(trig_req),
    .external_trigger_signal(trig));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    pwm_q <= pwm_drive;
    if (pwm_drive === 1'b1 && pwm_q === 1'b0) rises <= rises + 1;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      test_done();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task bus(input logic wr, input logic [ADDR_W-1:0] a,
           input logic [DATA_W-1:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task wait_match();
    n = 0;
    while (timer_match_output !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, timer_match_output}, 32'h1);
  endtask : wait_match
  task test_done();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, CTRL_OFS, '0);
    chk(d, 32'h0);
    bus(1'b0, PERIOD_OFS, '0);
    chk(d, 32'h0000_00ff);
    bus(1'b1, 4'h2, 32'h0000_1f01);
    bus(1'b0, 4'h2, '0);
    chk(d, 32'h0);
    bus(1'b0, CTRL_OFS, '0);
    chk(d, 32'h0);
    $display("test reset and unmapped done");
    bus(1'b1, PERIOD_OFS, 32'h5);
    bus(1'b1, PULSE_OFS, 32'h3);
    foreach (rows[i]) begin
      trig_req <= rows[i].l0;
      bus(1'b1, CTRL_OFS, {19'h0, rows[i].mode, 8'h00});
      repeat (6) @(posedge clk);
      base = rises;
      bus(1'b1, CTRL_OFS, {19'h0, rows[i].mode, 8'h01});
      if (rows[i].l0 != rows[i].l1) begin
        repeat (5) @(posedge clk);
        chk({24'h0, timer_count}, 32'h0);
        trig_req <= rows[i].l1;
      end
      wait_match();
      repeat (3) @(posedge clk);
      bus(1'b0, STATUS_OFS, '0);
      chk(d & 32'h0003_00ff, {14'h0, rows[i].run, 9'h0, rows[i].cnt});
      chk(rises - base, 1);
      $display("test row %0d done", i);
    end
    trig_req <= 1'b0;
    bus(1'b1, PERIOD_OFS, 32'h14);
    bus(1'b1, CTRL_OFS, {19'h0, MODE_HLE_RISE, 8'h01});
    repeat (4) @(posedge clk);
    trig_req <= 1'b1;
    repeat (12) @(posedge clk);
    trig_req <= 1'b0;
    repeat (4) @(posedge clk);
    base = rises;
    trig_req <= 1'b1;
    n = 0;
    while (pwm_drive !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk({24'h0, timer_count}, 32'h0);
    @(posedge clk);
    chk({24'h0, timer_count}, 32'h0);
    @(posedge clk);
    chk({24'h0, timer_count}, 32'h1);
    chk(rises - base, 1);
    wait_match();
    repeat (2) @(posedge clk);
    base = rises;
    trig_req <= 1'b0;
    repeat (4) @(posedge clk);
    trig_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk({24'h0, timer_count}, 32'h0);
    chk(rises - base, 0);
    $display("test hardware limit done");
    test_done();
  end
endmodule : tb_tos_timer
bind tos_timer tos_timer_monitor #(.CNT_W(CNT_W)) i_tos_timer_monitor (
  .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .external_trigger_signal(external_trigger_signal),
  .timer_count(timer_count), .pwm_drive(pwm_drive),
  .timer_match_output(timer_match_output));

// ---- test/tos_timer_monitor.sv ----
`timescale 1ns/1ps
module tos_timer_monitor
  import tos_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              external_trigger_signal,
  input wire logic [CNT_W-1:0]  timer_count,
  input wire logic              pwm_drive,
  input wire logic              timer_match_output
);
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] pulse_q;
  logic             req;
  logic             wr_acc;
  assign req = avs_read | avs_write;
  assign wr_acc = avs_write & ~avs_waitrequest;
  // shadow copies, taken only at the accepting edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      period_q <= '1;
      pulse_q  <= '0;
    end else if (wr_acc && avs_byteenable[0]) begin
      if (avs_address == PERIOD_OFS) period_q <= avs_writedata[CNT_W-1:0];
      if (avs_address == PULSE_OFS) pulse_q <= avs_writedata[CNT_W-1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_wait_first: assert property (req && avs_waitrequest |=>
    !avs_waitrequest || !req) else $error("no answer after one wait");
  a_wait_again: assert property (req && !avs_waitrequest |=>
    avs_waitrequest || !req) else $error("request answered twice");
  a_idle_nowait: assert property (!req |-> !avs_waitrequest)
    else $error("wait while idle");
  a_read_upper: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:19] == '0) else $error("unused bits not zero");
  a_read_unmapped: assert property (avs_read && !avs_waitrequest &&
    avs_address[1:0] != 2'h0 |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  a_count_step: assert property (!$stable(timer_count) |->
    timer_count == CNT_W'($past(timer_count) + 1'b1) || timer_count == '0)
    else $error("count jumped");
  a_match_period: assert property (timer_match_output |->
    $past(timer_count) == $past(period_q)) else $error("match off period");
  a_pwm_fall: assert property ($fell(pwm_drive) |->
    $past(timer_count) == $past(pulse_q) || timer_match_output ||
    $past(wr_acc)) else $error("drive dropped without cause");
  c_match: cover property (timer_match_output);
  c_pwm: cover property ($rose(pwm_drive));
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule : tos_timer_monitor

// ---- test/tos_trig_src.sv ----
`timescale 1ns/1ps
module tos_trig_src (
  input  wire logic clk,
  input  wire logic level_req,
  output logic      external_trigger_signal
);
  // moves just after the rising edge, like every other design input
  always_ff @(posedge clk) begin
    external_trigger_signal <= level_req;
  end
endmodule : tos_trig_src
